// File: rtl/ready_wait_timer.sv
// Purpose: Shared constants and the driver-ready wait timer.
// Assumes: One 20 MHz clock, synchronous active-high reset.
// Notes: The timer only counts while its run input is held.

package interlock_pkg;
  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned READY_WAIT_S = 3;
  localparam int unsigned READY_WAIT_CYCLES = READY_WAIT_S * CLK_HZ;
  localparam int TMR_W = 26;

  // ------------------------------------------------------------------
  // Parameter encoding and alarm code
  // ------------------------------------------------------------------
  localparam logic GATE_DISABLE = 1'b0;
  localparam logic GATE_ENABLE = 1'b1;
  localparam logic GATE_FACTORY_DEFAULT = GATE_DISABLE;
  localparam logic [7:0] ALARM_NONE = 8'h00;
  localparam logic [7:0] ALARM_DRIVER_CONNECTION = 8'h6f;

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_RUN = 2'b11,
    ST_ALARM = 2'b10
  } motion_state_e;

  // Host command towards the enable parameter
  typedef struct packed {
    logic imm_write;
    logic imm_read;
    logic seq_write;
    logic seq_read;
    logic save;
    logic data;
  } param_cmd_s;

  // Parameter read-back: staged (unsaved) value and value in force
  typedef struct packed {
    logic valid;
    logic staged;
    logic active;
  } param_rd_s;

  // Nonvolatile image of the enable parameter
  typedef struct packed {
    logic valid;
    logic value;
  } nv_image_s;
endpackage

`timescale 1ns/1ps

module ready_wait_timer #(
  parameter int unsigned limit = interlock_pkg::READY_WAIT_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic run,
  output logic expired
);
  import interlock_pkg::*;

  localparam logic [TMR_W-1:0] LAST = TMR_W'(limit - 1);

  logic [TMR_W-1:0] cnt_r;

  // Restarts from zero every time run drops, so each wait is timed afresh
  always_ff @(posedge clk) begin
    if (rst || !run) begin
      cnt_r <= '0;
    end else if (cnt_r != LAST) begin
      cnt_r <= cnt_r + TMR_W'(1);
    end
  end

  assign expired = run && (cnt_r == LAST);
endmodule // ready_wait_timer

// File: rtl/driver_ready_interlock.sv
// Purpose: Gate motion start on the driver ready input and drive ready out.
// Assumes: Inputs synchronous to clk; nonvolatile image stable at reset.
// Notes: The enable parameter in force changes only during reset and at reset release.
//
// Notes on behaviour
// R1: One-bit enable: 0 ignores, 1 honours ready.
// R2: Enable defaults to 0 when never saved.
// R3: New value applies only after save and reset.
// R4: Power-up loads last saved value, unsaved lost.
// R5: Nothing saved: load factory default at power-up.
// R6: Host reads/writes; sequences may only read.
// R7: Enabled start first samples driver ready input.
// R8: Ready at start: pulses begin without delay.
// R9: Not ready: hold pulses until ready rises.
// R10: Three seconds not ready: alarm code 0x6f.
// R11: Enabled: ready out needs idle and driver ready.
// R12: Disabled: ready out ignores driver ready input.
// R13: On timeout alarm, pending motion is dropped.

`timescale 1ns/1ps

module driver_ready_interlock #(
  parameter int unsigned timeout_cycles = interlock_pkg::READY_WAIT_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Parameter commands and nonvolatile storage
  input wire interlock_pkg::param_cmd_s param_cmd,
  output interlock_pkg::param_rd_s param_rd,
  output logic seq_write_refused,
  input wire interlock_pkg::nv_image_s nv_image,
  output logic nv_write,
  output logic nv_write_data,
  // Motion sequencing
  input wire logic start_req,
  input wire logic motion_done,
  input wire logic program_running,
  input wire logic alarm_clear,
  output logic pulse_enable,
  output logic motion_pending,
  output logic alarm_active,
  output logic [7:0] alarm_code,
  // Driver and I/O connector
  input wire logic driver_ready_input_status,
  output logic controller_ready_local,
  output logic controller_ready_remote,
  output logic driver_ready_gate_enable
);
  import interlock_pkg::*;

  // ------------------------------------------------------------------
  // Parameter storage
  // ------------------------------------------------------------------
  logic loaded_r;
  logic gate_en_r;
  logic staged_r;
  logic nv_write_r;
  logic nv_write_data_r;
  param_rd_s param_rd_r;
  logic seq_refused_r;

  function automatic logic power_up_value(input nv_image_s img);
    return img.valid ? img.value : GATE_FACTORY_DEFAULT;
  endfunction

  // The image is caught by a clocked load one edge after reset release
  always_ff @(posedge clk) begin
    if (rst) begin
      loaded_r <= 1'b0;
      gate_en_r <= GATE_FACTORY_DEFAULT; // R2
    end else if (!loaded_r) begin
      loaded_r <= 1'b1;
      gate_en_r <= power_up_value(nv_image); // R4 R5 R3
    end
  end

  // Staged copy is what the host edits; it never steers the interlock
  always_ff @(posedge clk) begin
    if (rst) begin
      staged_r <= GATE_FACTORY_DEFAULT;
    end else if (!loaded_r) begin
      staged_r <= power_up_value(nv_image); // R4
    end else if (param_cmd.imm_write) begin
      staged_r <= param_cmd.data; // R6 R1
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      nv_write_r <= 1'b0;
      nv_write_data_r <= GATE_FACTORY_DEFAULT;
    end else begin
      nv_write_r <= loaded_r && param_cmd.save; // R3
      if (loaded_r && param_cmd.save) begin
        nv_write_data_r <= staged_r;
      end
    end
  end

  // Sequence writes are refused and flagged for one cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      param_rd_r <= '0;
      seq_refused_r <= 1'b0;
    end else begin
      param_rd_r.valid <= loaded_r && (param_cmd.imm_read || param_cmd.seq_read); // R6
      param_rd_r.staged <= staged_r;
      param_rd_r.active <= gate_en_r;
      seq_refused_r <= param_cmd.seq_write; // R6
    end
  end

  // ------------------------------------------------------------------
  // Motion start interlock
  // ------------------------------------------------------------------
  motion_state_e state_r;
  motion_state_e state_nxt;
  logic wait_expired;
  logic start_ok;
  logic drv_gate_ok;

  ready_wait_timer #(
    .limit(timeout_cycles)
  ) u_timer (
    .clk(clk),
    .rst(rst),
    .run(state_r == ST_WAIT),
    .expired(wait_expired)
  );

  // Starts are refused until the parameter has been loaded
  assign start_ok = loaded_r && start_req;
  assign drv_gate_ok = (gate_en_r == GATE_DISABLE) || driver_ready_input_status; // R1 R7

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (start_ok) begin
          state_nxt = drv_gate_ok ? ST_RUN : ST_WAIT; // R7 R8 R9
        end
      end
      ST_WAIT: begin
        // Ready arriving on the expiry cycle still wins the race
        if (driver_ready_input_status) begin
          state_nxt = ST_RUN; // R9
        end else if (wait_expired) begin
          state_nxt = ST_ALARM; // R10 R13
        end
      end
      ST_RUN: begin
        if (motion_done) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_ALARM: begin
        if (alarm_clear) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Alarm and outputs
  // ------------------------------------------------------------------
  logic [7:0] alarm_code_r;
  logic ready_out_r;
  logic pulse_en_r;
  logic pending_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      alarm_code_r <= ALARM_NONE;
    end else if (state_nxt == ST_ALARM && state_r == ST_WAIT) begin
      alarm_code_r <= ALARM_DRIVER_CONNECTION; // R10
    end else if (state_r == ST_ALARM && alarm_clear) begin
      alarm_code_r <= ALARM_NONE;
    end
  end

  // Pulses only ever run in the run state; the alarm path skips it
  always_ff @(posedge clk) begin
    if (rst) begin
      pulse_en_r <= 1'b0;
      pending_r <= 1'b0;
    end else begin
      pulse_en_r <= (state_nxt == ST_RUN); // R8 R13
      pending_r <= (state_nxt == ST_WAIT); // R9
    end
  end

  // Ready out lags its inputs by one clock, far below connector timing
  always_ff @(posedge clk) begin
    if (rst) begin
      ready_out_r <= 1'b0;
    end else begin
      ready_out_r <= loaded_r && (state_nxt == ST_IDLE) && !program_running
                     && drv_gate_ok; // R11 R12
    end
  end

  assign param_rd = param_rd_r;
  assign seq_write_refused = seq_refused_r;
  assign nv_write = nv_write_r;
  assign nv_write_data = nv_write_data_r;
  assign pulse_enable = pulse_en_r;
  assign motion_pending = pending_r;
  assign alarm_active = (state_r == ST_ALARM);
  assign alarm_code = alarm_code_r;
  assign controller_ready_local = ready_out_r;
  assign controller_ready_remote = ready_out_r;
  assign driver_ready_gate_enable = gate_en_r;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence idle_start_s;
    state_r == ST_IDLE && start_ok;
  endsequence

  sequence held_off_s;
    state_r == ST_WAIT && !driver_ready_input_status;
  endsequence

  power_load_a: assert property ($rose(loaded_r) |-> gate_en_r == // R4 R5 R2
      ($past(nv_image.valid) ? $past(nv_image.value) : GATE_FACTORY_DEFAULT))
    else $error("Enable not loaded from saved image");

  active_stable_a: assert property (loaded_r && $past(loaded_r) |-> $stable(gate_en_r)) // R3
    else $error("Enable in force changed without reset");

  save_image_a: assert property (loaded_r && param_cmd.save |=> // R3
      nv_write && nv_write_data == $past(staged_r))
    else $error("Save did not write staged value");

  seq_readonly_a: assert property (loaded_r && param_cmd.seq_write && !param_cmd.imm_write // R6
      |=> $stable(staged_r) && seq_write_refused)
    else $error("Sequence write altered enable");

  start_direct_a: assert property (idle_start_s ##0 drv_gate_ok |=> pulse_enable) // R8
    else $error("Start with ready did not pulse at once");

  start_hold_a: assert property (idle_start_s ##0 !drv_gate_ok // R7 R9
      |=> !pulse_enable && motion_pending)
    else $error("Start without ready was not held off");

  wait_release_a: assert property (state_r == ST_WAIT && driver_ready_input_status // R9
      |=> pulse_enable && !motion_pending)
    else $error("Held start did not begin on ready");

  timeout_alarm_a: assert property (held_off_s ##0 wait_expired // R10 R13
      |=> alarm_active && alarm_code == ALARM_DRIVER_CONNECTION ##0 !pulse_enable [*2])
    else $error("Wait expiry did not raise connection alarm");

  ready_gate_a: assert property (gate_en_r && !driver_ready_input_status // R11
      |=> !controller_ready_local && !controller_ready_remote)
    else $error("Ready out raised while driver not ready");

  ready_free_a: assert property (loaded_r && !gate_en_r && state_nxt == ST_IDLE // R12
      && !program_running |=> controller_ready_local)
    else $error("Ready out missing with gate disabled");

  ready_mirror_a: assert property ( // R11 R12
      controller_ready_remote == controller_ready_local)
    else $error("Remote ready differs from local ready");

  wait_quiet_a: assert property (state_r == ST_WAIT |-> !pulse_enable) // R9
    else $error("Pulses issued while waiting for driver ready");

  alarm_hold_a: assert property (alarm_active && !alarm_clear |=> alarm_active) // R10
    else $error("Connection alarm dropped without clear");

  alarm_clear_a: assert property (alarm_active && alarm_clear // R10
      |=> !alarm_active && alarm_code == ALARM_NONE)
    else $error("Alarm clear did not return to idle");

  read_back_a: assert property (loaded_r && param_cmd.imm_read // R6
      |=> param_rd.valid && param_rd.active == $past(gate_en_r))
    else $error("Read did not return enable in force");

  staged_write_a: assert property (loaded_r && param_cmd.imm_write // R6 R1
      |=> staged_r == $past(param_cmd.data))
    else $error("Host write not staged");

  gate_ignored_a: assert property (idle_start_s ##0 gate_en_r == GATE_DISABLE // R1 R12
      |=> pulse_enable && !motion_pending)
    else $error("Start held although gate disabled");

  alarm_silent_a: assert property (alarm_active |-> !pulse_enable && !motion_pending) // R13
    else $error("Motion left pending or pulsing in alarm");
endmodule // driver_ready_interlock

// File: verif/stepper_driver_model.sv
// Purpose: Behavioural stepping motor driver facing the interlock.
// Assumes: The bench states the wanted ready level and the lag to reach it.
// Notes: Ready is a plain level; a lag of zero answers at the next edge.

`timescale 1ns/1ps

module stepper_driver_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bench control
  input wire logic want_ready,
  input wire logic [7:0] lag,
  // Driver connector
  output logic ready
);
  logic [7:0] cnt_r;

  // --------------------------------------------------------------
  // Ready level follows the request after a programmable lag
  // --------------------------------------------------------------
  // Slow answers let the bench hold a start in the waiting state.
  always_ff @(posedge clk) begin
    if (rst || want_ready == ready) begin
      cnt_r <= 8'h00;
      if (rst) ready <= 1'b0;
    end else if (cnt_r >= lag) begin
      ready <= want_ready;
      cnt_r <= 8'h00;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
endmodule // stepper_driver_model

// File: verif/tb.sv
// Purpose: Self-checking bench for the driver ready interlock.
// Assumes: Short wait timer; inputs change at the falling edge.
// Notes: Parameter events are queued by the main sequence, matched by a watcher.

`timescale 1ns/1ps

module tb;
  import interlock_pkg::*;
  localparam int unsigned TO = 20;
  logic clk = 0, rst = 1, start_req = 0, motion_done = 0;
  logic program_running = 0, alarm_clear = 0, want_ready = 0, drv_ready;
  logic seq_write_refused, nv_write, nv_write_data, pulse_enable, motion_pending;
  logic alarm_active, ready_loc, ready_rem, gate_en, seen_pulse, d;
  logic [7:0] alarm_code, lag = 8'h00;
  param_cmd_s param_cmd = '0;
  param_rd_s param_rd;
  nv_image_s nv_image = '0;
  int fail_count = 0, total_checks = 0, n;
  logic [3:0] exp_q[$];

  always #25 clk = ~clk;

  driver_ready_interlock #(.timeout_cycles(TO)) dut_u (.clk(clk), .rst(rst),
    .param_cmd(param_cmd), .param_rd(param_rd), .seq_write_refused(seq_write_refused),
    .nv_image(nv_image), .nv_write(nv_write), .nv_write_data(nv_write_data),
    .start_req(start_req), .motion_done(motion_done), .program_running(program_running),
    .alarm_clear(alarm_clear), .pulse_enable(pulse_enable), .motion_pending(motion_pending),
    .alarm_active(alarm_active), .alarm_code(alarm_code),
    .driver_ready_input_status(drv_ready), .controller_ready_local(ready_loc),
    .controller_ready_remote(ready_rem), .driver_ready_gate_enable(gate_en));

  stepper_driver_model drv_u (.clk(clk), .rst(rst), .want_ready(want_ready), .lag(lag),
    .ready(drv_ready));

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic take(input logic [3:0] g);
    if (exp_q.size() == 0) check("unexpected event", {4'h0, g}, 8'hff);
    else check("parameter event", {4'h0, g}, {4'h0, exp_q.pop_front()});
  endtask

  // Event code: 0=read {staged,active}, 1=nv write data, 2=refused write
  always @(negedge clk) begin
    if (!rst) begin
      if (param_rd.valid === 1'b1) take({2'd0, param_rd.staged, param_rd.active});
      if (nv_write === 1'b1) take({2'd1, 1'b0, nv_write_data});
      if (seq_write_refused === 1'b1) take(4'b1000);
    end
  end

  // ----------------------------------------------------------------
  // Stimulus helpers
  // ----------------------------------------------------------------
  task automatic tick(input int k);
    repeat (k) @(negedge clk);
  endtask

  task automatic cmd(input param_cmd_s c);
    @(negedge clk) param_cmd = c;
    @(negedge clk) param_cmd = '0;
  endtask

  task automatic pulse_start;
    @(negedge clk) start_req = 1;
    @(negedge clk) start_req = 0;
  endtask

  task automatic finish_motion;
    @(negedge clk) motion_done = 1;
    @(negedge clk) motion_done = 0;
    tick(1);
    check("pulse enable off", {7'h0, pulse_enable}, 8'h00);
  endtask

  task automatic ready_chk(input logic exp);
    tick(2);
    check("ready local", {7'h0, ready_loc}, {7'h0, exp});
    check("ready remote", {7'h0, ready_rem}, {7'h0, exp});
  endtask

  // Nonvolatile image is set up before reset, as power-up would see it
  task automatic do_reset(input nv_image_s img);
    nv_image = img;
    rst = 1;
    tick(8);
    check("gate during reset", {7'h0, gate_en}, 8'h00);
    rst = 0;
    tick(2);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(4));
    do_reset('{valid: 1'b0, value: 1'b1});
    check("gate default", {7'h0, gate_en}, {7'h0, GATE_FACTORY_DEFAULT});
    ready_chk(1);
    pulse_start;
    check("pulse disabled gate", {7'h0, pulse_enable}, 8'h01);
    finish_motion;
    cmd('{imm_write: 1'b1, data: 1'b1, default: 1'b0});
    exp_q.push_back(4'b0010);
    cmd('{imm_read: 1'b1, default: 1'b0});
    exp_q.push_back(4'b1000);
    cmd('{seq_write: 1'b1, data: 1'b0, default: 1'b0});
    exp_q.push_back(4'b0010);
    cmd('{seq_read: 1'b1, default: 1'b0});
    exp_q.push_back(4'b0101);
    cmd('{save: 1'b1, default: 1'b0});
    tick(2);
    check("gate before reset", {7'h0, gate_en}, 8'h00);
    do_reset('{valid: 1'b1, value: 1'b1});
    check("gate loaded", {7'h0, gate_en}, 8'h01);
    ready_chk(0);
    want_ready = 1;
    ready_chk(1);
    program_running = 1;
    ready_chk(0);
    program_running = 0;
    pulse_start;
    check("pulse ready", {7'h0, pulse_enable}, 8'h01);
    ready_chk(0);
    finish_motion;
    want_ready = 0;
    tick(3);
    lag = 8'h05;
    pulse_start;
    check("pending", {7'h0, motion_pending}, 8'h01);
    check("held off", {7'h0, pulse_enable}, 8'h00);
    want_ready = 1;
    for (n = 0; n < 20 && pulse_enable !== 1'b1; n++) tick(1);
    check("late start", {7'h0, pulse_enable}, 8'h01);
    check("pending cleared", {7'h0, motion_pending}, 8'h00);
    finish_motion;
    want_ready = 0;
    lag = 8'h00;
    tick(3);
    pulse_start;
    seen_pulse = 0;
    for (n = 0; n < 200 && alarm_active !== 1'b1; n++) begin
      tick(1);
      if (pulse_enable !== 1'b0) seen_pulse = 1;
    end
    check("alarm code", alarm_code, ALARM_DRIVER_CONNECTION);
    check("timeout span", {7'h0, n >= TO - 2 && n <= TO + 3}, 8'h01);
    check("no pulses", {7'h0, seen_pulse}, 8'h00);
    check("motion dropped", {7'h0, motion_pending}, 8'h00);
    if (alarm_active !== 1'b1) give_verdict();
    @(negedge clk) alarm_clear = 1;
    @(negedge clk) alarm_clear = 0;
    tick(1);
    check("alarm cleared", alarm_code, ALARM_NONE);
    repeat (4) begin
      d = 1'($urandom());
      cmd('{imm_write: 1'b1, data: d, default: 1'b0});
      exp_q.push_back({2'd0, d, 1'b1});
      cmd('{imm_read: 1'b1, default: 1'b0});
    end
    exp_q.push_back({2'd1, 1'b0, d});
    cmd('{imm_write: 1'b1, save: 1'b1, data: ~d, default: 1'b0});
    exp_q.push_back({2'd0, ~d, 1'b1});
    cmd('{imm_read: 1'b1, default: 1'b0});
    tick(2);
    check("events left", 8'(exp_q.size()), 8'h00);
    give_verdict();
  end
endmodule // tb
